// file: core/ubs_uart_regs.svh
/*
  Register indices, field positions, reset values and fixed codes of the
  UART buffer, status and data block.
  Assumes a 32-bit AXI4-Lite bus where byte address = index * 4.
*/
`ifndef UBS_UART_REGS_SVH
`define UBS_UART_REGS_SVH

// Register indices; byte address is four times the index
`define UBS_IDX_IE 16'hc00e
`define UBS_IDX_CTRL 16'hc0e0
`define UBS_IDX_STAT 16'hc0e2
`define UBS_IDX_DATA 16'hc0e4

// Field positions
`define UBS_IE_UART_BIT 0
`define UBS_CTRL_EN_BIT 0
`define UBS_CTRL_BAUD_LSB 1
`define UBS_CTRL_BAUD_MSB 3
`define UBS_CTRL_PRE_BIT 4
`define UBS_STAT_TXF_BIT 0
`define UBS_STAT_RXF_BIT 1
`define UBS_REG_W 16
`define UBS_BYTE_W 8

// Reset values
`define UBS_CTRL_RESET 16'h0007
`define UBS_IE_RESET 16'h0000

// Bit rate: multiples of the base period for codes 0..7, and prescaler
`define UBS_BAUD_BASE 115200
`define UBS_BAUD_K0 1
`define UBS_BAUD_K1 2
`define UBS_BAUD_K2 3
`define UBS_BAUD_K3 4
`define UBS_BAUD_K4 6
`define UBS_BAUD_K5 8
`define UBS_BAUD_K6 12
`define UBS_BAUD_K7 16
`define UBS_PRESCALE_DIV 8
`define UBS_LAST_BIT 3'h7

// AXI responses
`define UBS_RESP_OKAY 2'h0
`define UBS_RESP_DECERR 2'h3

`endif

// file: core/ubs_pkg.sv
/*
  Shared types of the UART buffer, status and data block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ubs_pkg;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_STOP
  } ubs_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } ubs_rx_state_t;

endpackage : ubs_pkg

// file: core/ubs_fifo_if.sv
/*
  Valid/ready carrier between the UART top and its transmit FIFO.
  Assumes both ends run on the same clock.
*/
interface ubs_fifo_if #(parameter int WIDTH = 8);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport filler (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
  modport store (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
endinterface : ubs_fifo_if

// file: core/ubs_fifo.sv
/*
  Synchronous FIFO holding transmit bytes between the data register and
  the serializer.
  Assumes DEPTH is a power of two and one clock for both sides.
*/
module ubs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  ubs_fifo_if.store f
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
  } ubs_fifo_state_t;

  ubs_fifo_state_t s_reg;
  ubs_fifo_state_t s_next;
  logic empty;
  logic full;

  // Extra pointer bit tells full from empty without a counter
  assign empty = s_reg.wr_ptr == s_reg.rd_ptr;
  assign full = (s_reg.wr_ptr[PW] != s_reg.rd_ptr[PW]) &&
                (s_reg.wr_ptr[PW-1:0] == s_reg.rd_ptr[PW-1:0]);
  assign f.push_ready = !full;
  assign f.pop_valid = !empty;
  assign f.pop_data = s_reg.mem[s_reg.rd_ptr[PW-1:0]];

  always_comb begin
    s_next = s_reg;
    if (f.push_valid && !full) begin
      s_next.mem[s_reg.wr_ptr[PW-1:0]] = f.push_data;
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    if (f.pop_ready && !empty) begin
      s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : ubs_fifo

// file: core/ubs_uart.sv
/*
  UART buffer, status and data registers with serializer, deserializer,
  transmit FIFO and shared pin muxing, as an AXI4-Lite slave.
  Assumes pin inputs synchronous to clk_sys and an external interrupt
  controller taking the two interrupt levels.
*/
// The AXI4-Lite slave port is this design's own decision.
// Behaviour
// - Status register: bit1 rx full, bit0 tx full
// - Rx full set while unread byte held
// - Full receive buffer raises interrupt five
// - Reading data register clears rx full
// - Tx full while byte pending or sending
// - Empty transmit buffer raises interrupt four
// - Data write loads byte, starts sending
// - Tx full clears after byte shifted out
// - Data register byte in bits seven-zero
// - Transmit drives shared pin seven when enabled
// - Receive samples shared pin six when enabled
// - Enable bit; disabled releases both pins
// - Three-bit baud select, 115.2 to 7.2k
// - Prescale bit divides bit rate by eight
`include "ubs_uart_regs.svh"

module ubs_uart #(
  parameter int AW = 20,
  parameter int CLK_HZ = 25000000,
  parameter int BAUD_BASE = `UBS_BAUD_BASE,
  parameter int FIFO_DEPTH = 8,
  parameter int CW = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic shared_pin_seven_i,
  output logic shared_pin_seven_o,
  output logic shared_pin_seven_oe,
  input wire logic shared_pin_six_i,
  output logic shared_pin_six_o,
  output logic shared_pin_six_oe,
  input wire logic gp_seven_out,
  input wire logic gp_seven_oe,
  input wire logic gp_six_out,
  input wire logic gp_six_oe,
  output logic cpu_irq_rx,
  output logic cpu_irq_tx
);
  localparam int BASE_CYC = (CLK_HZ / BAUD_BASE > 0) ? CLK_HZ / BAUD_BASE : 1;
  localparam int K_TAB [8] = '{`UBS_BAUD_K0, `UBS_BAUD_K1, `UBS_BAUD_K2, `UBS_BAUD_K3,
                               `UBS_BAUD_K4, `UBS_BAUD_K5, `UBS_BAUD_K6, `UBS_BAUD_K7};

  typedef struct packed {
    logic aw_held;
    logic [AW-1:0] aw_addr;
    logic w_held;
    logic [`UBS_REG_W-1:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [`UBS_REG_W-1:0] rdata;
    logic [1:0] rresp;
    logic uart_en;
    logic [2:0] baud_sel;
    logic prescale;
    logic uart_ie;
    logic rx_full;
    logic [`UBS_BYTE_W-1:0] rx_byte;
    ubs_pkg::ubs_tx_state_t tx_state;
    logic [CW-1:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [`UBS_BYTE_W-1:0] tx_shift;
    logic tx_line;
    ubs_pkg::ubs_rx_state_t rx_state;
    logic [CW-1:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [`UBS_BYTE_W-1:0] rx_shift;
  } ubs_state_t;

  ubs_state_t s_reg;
  ubs_state_t s_next;

  // Exact word match; low address bits must be zero
  function automatic logic addr_is(input logic [AW-1:0] addr, input logic [15:0] idx);
    return addr == AW'({idx, 2'b00});
  endfunction : addr_is

  // Reload value of a bit-period down-counter, one less than the period
  function automatic logic [CW-1:0] bit_reload(input logic [2:0] sel, input logic pre);
    int cyc;
    cyc = BASE_CYC * K_TAB[sel] * (pre ? `UBS_PRESCALE_DIV : 1);
    return CW'(cyc - 1);
  endfunction : bit_reload

  ubs_fifo_if #(.WIDTH(`UBS_BYTE_W)) tx_q ();

  ubs_fifo #(
    .WIDTH(`UBS_BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .f(tx_q.store)
  );

  logic wr_is_data;
  logic wr_hit;
  logic wr_go;
  logic ar_fire;
  logic rd_data_fire;
  logic tx_full;
  logic tx_tick;
  logic rx_tick;
  logic rx_line;
  logic rx_done;
  logic [`UBS_REG_W-1:0] rd_value;
  logic rd_hit;
  logic [CW-1:0] reload;

  assign reload = bit_reload(s_reg.baud_sel, s_reg.prescale);
  assign wr_is_data = addr_is(s_reg.aw_addr, `UBS_IDX_DATA);
  assign wr_hit = wr_is_data || addr_is(s_reg.aw_addr, `UBS_IDX_CTRL) ||
                  addr_is(s_reg.aw_addr, `UBS_IDX_STAT) || addr_is(s_reg.aw_addr, `UBS_IDX_IE);
  // Data writes wait for FIFO room: back-pressure reaches the bus master
  assign tx_q.push_valid = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid &&
                           wr_is_data && s_reg.w_strb0;
  assign tx_q.push_data = s_reg.w_data[`UBS_BYTE_W-1:0];
  assign wr_go = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid &&
                 (!tx_q.push_valid || tx_q.push_ready);
  assign ar_fire = s_axi_arvalid && !s_reg.rvalid;
  assign rd_data_fire = ar_fire && addr_is(s_axi_araddr, `UBS_IDX_DATA);

  assign tx_tick = s_reg.tx_cnt == '0;
  assign rx_tick = s_reg.rx_cnt == '0;
  assign rx_line = s_reg.uart_en ? shared_pin_six_i : 1'b1;
  assign tx_q.pop_ready = s_reg.uart_en && s_reg.tx_state == ubs_pkg::TX_IDLE;
  assign tx_full = tx_q.pop_valid || s_reg.tx_state != ubs_pkg::TX_IDLE;
  assign rx_done = s_reg.rx_state == ubs_pkg::RX_STOP && rx_tick && rx_line;

  // Read multiplexer; reserved bits read as zero
  always_comb begin
    rd_value = '0;
    rd_hit = 1'b1;
    if (addr_is(s_axi_araddr, `UBS_IDX_STAT)) begin
      rd_value[`UBS_STAT_RXF_BIT] = s_reg.rx_full;
      rd_value[`UBS_STAT_TXF_BIT] = tx_full;
    end else if (addr_is(s_axi_araddr, `UBS_IDX_DATA)) begin
      rd_value[`UBS_BYTE_W-1:0] = s_reg.rx_byte;
    end else if (addr_is(s_axi_araddr, `UBS_IDX_CTRL)) begin
      rd_value[`UBS_CTRL_EN_BIT] = s_reg.uart_en;
      rd_value[`UBS_CTRL_BAUD_MSB:`UBS_CTRL_BAUD_LSB] = s_reg.baud_sel;
      rd_value[`UBS_CTRL_PRE_BIT] = s_reg.prescale;
    end else if (addr_is(s_axi_araddr, `UBS_IDX_IE)) begin
      rd_value[`UBS_IE_UART_BIT] = s_reg.uart_ie;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    s_next = s_reg;
    // Write address and data may arrive in either order
    if (s_axi_awvalid && !s_reg.aw_held) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_held) begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata[`UBS_REG_W-1:0];
      s_next.w_strb0 = s_axi_wstrb[0];
    end
    if (wr_go) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wr_hit ? `UBS_RESP_OKAY : `UBS_RESP_DECERR;
      // Reserved bits are simply not stored, so stray ones do no harm
      if (s_reg.w_strb0 && addr_is(s_reg.aw_addr, `UBS_IDX_CTRL)) begin
        s_next.uart_en = s_reg.w_data[`UBS_CTRL_EN_BIT];
        s_next.baud_sel = s_reg.w_data[`UBS_CTRL_BAUD_MSB:`UBS_CTRL_BAUD_LSB];
        s_next.prescale = s_reg.w_data[`UBS_CTRL_PRE_BIT];
      end
      if (s_reg.w_strb0 && addr_is(s_reg.aw_addr, `UBS_IDX_IE)) begin
        s_next.uart_ie = s_reg.w_data[`UBS_IE_UART_BIT];
      end
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (ar_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_value;
      s_next.rresp = rd_hit ? `UBS_RESP_OKAY : `UBS_RESP_DECERR;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (rd_data_fire) begin
      s_next.rx_full = 1'b0;
    end

    // Serializer
    s_next.tx_cnt = tx_tick ? reload : s_reg.tx_cnt - 1'b1;
    unique case (s_reg.tx_state)
      ubs_pkg::TX_IDLE: begin
        s_next.tx_line = 1'b1;
        if (tx_q.pop_valid && tx_q.pop_ready) begin
          s_next.tx_shift = tx_q.pop_data;
          s_next.tx_state = ubs_pkg::TX_START;
          s_next.tx_line = 1'b0;
          s_next.tx_cnt = reload;
        end
      end
      ubs_pkg::TX_START: begin
        if (tx_tick) begin
          s_next.tx_state = ubs_pkg::TX_DATA;
          s_next.tx_bit = '0;
          s_next.tx_line = s_reg.tx_shift[0];
        end
      end
      ubs_pkg::TX_DATA: begin
        if (tx_tick) begin
          s_next.tx_shift = s_reg.tx_shift >> 1;
          s_next.tx_bit = s_reg.tx_bit + 1'b1;
          s_next.tx_line = s_reg.tx_shift[1];
          if (s_reg.tx_bit == `UBS_LAST_BIT) begin
            s_next.tx_state = ubs_pkg::TX_STOP;
            s_next.tx_line = 1'b1;
          end
        end
      end
      ubs_pkg::TX_STOP: begin
        if (tx_tick) begin
          s_next.tx_state = ubs_pkg::TX_IDLE;
        end
      end
    endcase

    // Deserializer: start bit checked at mid-bit, data sampled mid-bit
    s_next.rx_cnt = rx_tick ? reload : s_reg.rx_cnt - 1'b1;
    unique case (s_reg.rx_state)
      ubs_pkg::RX_IDLE: begin
        if (!rx_line) begin
          s_next.rx_state = ubs_pkg::RX_START;
          s_next.rx_cnt = reload >> 1;
        end
      end
      ubs_pkg::RX_START: begin
        if (rx_tick) begin
          s_next.rx_state = rx_line ? ubs_pkg::RX_IDLE : ubs_pkg::RX_DATA;
          s_next.rx_bit = '0;
        end
      end
      ubs_pkg::RX_DATA: begin
        if (rx_tick) begin
          s_next.rx_shift = {rx_line, s_reg.rx_shift[`UBS_BYTE_W-1:1]};
          s_next.rx_bit = s_reg.rx_bit + 1'b1;
          if (s_reg.rx_bit == `UBS_LAST_BIT) begin
            s_next.rx_state = ubs_pkg::RX_STOP;
          end
        end
      end
      ubs_pkg::RX_STOP: begin
        // A low stop bit is a framing error; the byte is dropped
        if (rx_tick) begin
          s_next.rx_state = ubs_pkg::RX_IDLE;
        end
      end
    endcase
    // Overrun overwrites the unread byte; set wins over a same-cycle read
    if (rx_done) begin
      s_next.rx_byte = s_reg.rx_shift;
      s_next.rx_full = 1'b1;
    end

    if (!s_reg.uart_en) begin
      s_next.tx_state = ubs_pkg::TX_IDLE;
      s_next.tx_line = 1'b1;
      s_next.rx_state = ubs_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.uart_en <= 1'(`UBS_CTRL_RESET >> `UBS_CTRL_EN_BIT);
      s_reg.baud_sel <= 3'(`UBS_CTRL_RESET >> `UBS_CTRL_BAUD_LSB);
      s_reg.prescale <= 1'(`UBS_CTRL_RESET >> `UBS_CTRL_PRE_BIT);
      s_reg.uart_ie <= 1'(`UBS_IE_RESET >> `UBS_IE_UART_BIT);
      s_reg.tx_line <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = !s_reg.aw_held;
  assign s_axi_wready = !s_reg.w_held;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rdata = {{(32-`UBS_REG_W){1'b0}}, s_reg.rdata};

  // Pins fall back to the general-purpose port when the UART is off
  assign shared_pin_seven_o = s_reg.uart_en ? s_reg.tx_line : gp_seven_out;
  assign shared_pin_seven_oe = s_reg.uart_en ? 1'b1 : gp_seven_oe;
  assign shared_pin_six_o = gp_six_out;
  assign shared_pin_six_oe = s_reg.uart_en ? 1'b0 : gp_six_oe;

  assign cpu_irq_rx = s_reg.uart_ie && s_reg.rx_full;
  assign cpu_irq_tx = s_reg.uart_ie && !tx_full;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_STATUS_RSVD: assert property (
    ar_fire && addr_is(s_axi_araddr, `UBS_IDX_STAT) |=>
      s_axi_rvalid && s_axi_rdata[31:2] == '0 && s_axi_rdata[1] == $past(s_reg.rx_full))
    else $error("status read shows reserved bits or wrong rx flag");
  AST_RX_SET: assert property (
    rx_done |=> s_reg.rx_full && s_reg.rx_byte == $past(s_reg.rx_shift))
    else $error("received byte not latched as full");
  // A register write in the same cycle may legally clear the enable
  AST_IRQ_RX: assert property (rx_done && s_reg.uart_ie && !wr_go |=> cpu_irq_rx)
    else $error("rx interrupt missing");
  AST_RX_CLEAR: assert property (rd_data_fire && !rx_done |=> !s_reg.rx_full)
    else $error("data read did not clear rx full");
  AST_TX_BUSY: assert property (
    ar_fire && addr_is(s_axi_araddr, `UBS_IDX_STAT) && s_reg.tx_state != ubs_pkg::TX_IDLE
      |=> s_axi_rvalid && s_axi_rdata[0])
    else $error("tx full low while sending");
  AST_IRQ_TX: assert property (
    s_reg.uart_ie && s_reg.tx_state == ubs_pkg::TX_STOP && tx_tick && !tx_q.pop_valid &&
      !wr_go |=> cpu_irq_tx)
    else $error("tx empty interrupt missing");
  AST_WR_START: assert property (
    tx_q.push_valid && tx_q.push_ready && s_reg.uart_en &&
      s_reg.tx_state == ubs_pkg::TX_IDLE && !tx_q.pop_valid |=> tx_full ##1 !shared_pin_seven_o)
    else $error("data write did not start a frame");
  AST_STOP_HIGH: assert property (
    s_reg.uart_en && s_reg.tx_state == ubs_pkg::TX_STOP |->
      shared_pin_seven_o && shared_pin_seven_oe)
    else $error("stop bit not high on pin seven");
  AST_BIT_TIME: assert property (
    s_reg.tx_state == ubs_pkg::TX_DATA && tx_tick |=> s_reg.tx_cnt == $past(reload))
    else $error("bit period not reloaded from baud select");
  AST_DISABLE: assert property (
    !s_reg.uart_en && !s_next.uart_en |=> s_reg.tx_state == ubs_pkg::TX_IDLE &&
      !shared_pin_six_oe == !gp_six_oe)
    else $error("disabled UART still active");
endmodule : ubs_uart

// file: test/ubs_serial_peer.sv
/*
  Far-side serial device model: sends and receives 8N1 frames.
  Assumes bit_cyc holds the bit period in clk_sys cycles.
*/
module ubs_serial_peer (
  input wire logic clk_sys,
  input wire logic rx_line,
  output logic tx_line,
  input wire logic [15:0] bit_cyc,
  input wire logic send_go,
  input wire logic [7:0] send_byte,
  output logic got_pulse,
  output logic [7:0] got_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] frame;
  logic [7:0] shf;
  initial begin
    tx_line = 1'b1;
    got_pulse = 1'b0;
    got_byte = 8'h00;
  end
  // Start low, data LSB first, stop high, then idle high
  always @(posedge clk_sys) begin
    if (send_go === 1'b1) begin
      frame = {1'b1, send_byte, 1'b0};
      for (int i = 0; i < 10; i++) begin
        tx_line <= frame[i];
        repeat (bit_cyc) @(posedge clk_sys);
      end
    end
  end
  // Mid-bit sampling; a low stop bit drops the byte
  always @(posedge clk_sys) begin
    if (rx_line === 1'b0) begin
      repeat (bit_cyc / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk_sys);
        shf[i] = rx_line;
      end
      repeat (bit_cyc) @(posedge clk_sys);
      if (rx_line === 1'b1) begin
        got_byte <= shf;
        got_pulse <= 1'b1;
        @(posedge clk_sys);
      end
      got_pulse <= 1'b0;
    end
  end
endmodule : ubs_serial_peer

// file: test/uart_buffer_status_data_tb_top.sv
/*
  Self-checking bench of the UART register block against a serial peer.
  Assumes ubs_uart runs with CLK_HZ 1152000: base bit time 10 cycles.
*/
`include "ubs_uart_regs.svh"

module uart_buffer_status_data_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] A_IE = {2'h0, `UBS_IDX_IE, 2'h0};
  localparam logic [19:0] A_CTRL = {2'h0, `UBS_IDX_CTRL, 2'h0};
  localparam logic [19:0] A_STAT = {2'h0, `UBS_IDX_STAT, 2'h0};
  localparam logic [19:0] A_DATA = {2'h0, `UBS_IDX_DATA, 2'h0};
  localparam int KT [8] = '{1, 2, 3, 4, 6, 8, 12, 16};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [19:0] s_axi_awaddr = 20'h00000, s_axi_araddr = 20'h00000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic shared_pin_seven_i, shared_pin_seven_o, shared_pin_seven_oe;
  logic shared_pin_six_i, shared_pin_six_o, shared_pin_six_oe;
  logic gp_seven_out = 1'b1, gp_seven_oe = 1'b0, gp_six_out = 1'b0, gp_six_oe = 1'b0;
  logic cpu_irq_rx, cpu_irq_tx;
  logic peer_tx, got_pulse, send_go = 1'b0;
  logic [7:0] got_byte, send_byte = 8'h00;
  logic [15:0] bit_cyc = 16'h0028;
  logic [7:0] rxq[$];
  int miscompares = 0, num_checks = 0;
  logic [31:0] v;
  logic [1:0] rs;

  always #20 clk_sys = ~clk_sys;
  // Pull-up keeps the released transmit line idle high
  assign shared_pin_seven_i = shared_pin_seven_oe ? shared_pin_seven_o : 1'b1;
  assign shared_pin_six_i = shared_pin_six_oe ? shared_pin_six_o : peer_tx;

  ubs_uart #(.CLK_HZ(1152000)) uut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shared_pin_seven_i, .shared_pin_seven_o,
    .shared_pin_seven_oe, .shared_pin_six_i, .shared_pin_six_o, .shared_pin_six_oe,
    .gp_seven_out, .gp_seven_oe, .gp_six_out, .gp_six_oe, .cpu_irq_rx, .cpu_irq_tx);
  ubs_serial_peer peer (.clk_sys, .rx_line(shared_pin_seven_i), .tx_line(peer_tx), .bit_cyc,
    .send_go, .send_byte, .got_pulse, .got_byte);

  always @(posedge clk_sys) if (got_pulse === 1'b1) rxq.push_back(got_byte);

  task automatic complete_run;
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  task automatic wr(input logic [19:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  task automatic psend(input logic [7:0] b);
    @(posedge clk_sys);
    send_byte <= b;
    send_go <= 1'b1;
    @(posedge clk_sys);
    send_go <= 1'b0;
  endtask : psend

  // Bounded poll: a frame at the slowest rate used here is about 1600 cycles
  task automatic wait_stat(input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rd(A_STAT, v, rs);
      n++;
    end while (v !== e && n < 3000);
    chk(v, e, "status settle");
  endtask : wait_stat

  task automatic wait_q(input int n);
    for (int i = 0; i < 3000 && rxq.size() < n; i++) @(posedge clk_sys);
    chk(32'(rxq.size()), 32'(n), "peer count");
  endtask : wait_q

  task automatic t_reset;
    rd(A_STAT, v, rs);
    chk(v, 32'h0, "status reset");
    rd(A_DATA, v, rs);
    chk(v, 32'h0, "data reset");
    rd(A_CTRL, v, rs);
    chk(v, 32'h7, "ctrl reset");
    chk({29'h0, shared_pin_seven_oe, shared_pin_seven_o, shared_pin_six_oe}, 32'h6, "pins");
    chk({30'h0, cpu_irq_rx, cpu_irq_tx}, 32'h0, "irq masked");
  endtask : t_reset

  task automatic t_map;
    wr(20'h00004, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, `UBS_RESP_DECERR}, "unmapped wr");
    rd(20'h00004, v, rs);
    chk({30'h0, rs}, {30'h0, `UBS_RESP_DECERR}, "unmapped rd");
    wr(A_STAT, 32'h3, rs);
    rd(A_STAT, v, rs);
    chk(v, 32'h0, "status read-only");
  endtask : t_map

  task automatic t_tx;
    wr(A_CTRL, 32'h1, rs);
    bit_cyc <= 16'h000a;
    wr(A_IE, 32'h1, rs);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, cpu_irq_tx}, 32'h1, "tx empty irq");
    wr(A_DATA, 32'h0000005a, rs);
    rd(A_STAT, v, rs);
    chk(v, 32'h1, "tx full set");
    chk({31'h0, cpu_irq_tx}, 32'h0, "tx irq off");
    wait_q(1);
    wait_stat(32'h0);
    chk({24'h0, rxq[0]}, 32'h5a, "tx byte");
    rxq.delete();
  endtask : t_tx

  task automatic t_rx;
    psend(8'hc3);
    wait_stat(32'h2);
    chk({31'h0, cpu_irq_rx}, 32'h1, "rx irq");
    rd(A_DATA, v, rs);
    chk(v, 32'hc3, "rx byte");
    rd(A_STAT, v, rs);
    chk(v, 32'h0, "rx full clear");
    chk({31'h0, cpu_irq_rx}, 32'h0, "rx irq off");
  endtask : t_rx

  // One byte leaves for the shifter, eight fill the buffer, the tenth waits
  task automatic t_fifo;
    time t0;
    for (int i = 0; i < 10; i++) begin
      t0 = $time;
      wr(A_DATA, 32'h80 + 32'(i), rs);
    end
    chk(32'($time - t0 > 400), 32'h1, "full buffer stall");
    wait_q(10);
    for (int i = 0; i < 10; i++) chk({24'h0, rxq[i]}, 32'h80 + 32'(i), "order");
    wait_stat(32'h0);
    rxq.delete();
  endtask : t_fifo

  task automatic t_baud;
    int e;
    int n;
    for (int c = 0; c < 9; c++) begin
      e = 10 * KT[c % 8] * (c == 8 ? 8 : 1);
      wr(A_CTRL, 32'((c % 8) * 2 + 1 + (c == 8 ? 16 : 0)), rs);
      bit_cyc <= 16'(e);
      wr(A_DATA, 32'hff, rs);
      n = 0;
      while (shared_pin_seven_i !== 1'b0 && n < 400) begin
        @(posedge clk_sys);
        n++;
      end
      n = 0;
      while (shared_pin_seven_i === 1'b0 && n < 2000) begin
        @(posedge clk_sys);
        n++;
      end
      chk(32'(n), 32'(e), "start bit length");
      wait_stat(32'h0);
    end
    rxq.delete();
  endtask : t_baud

  task automatic t_disable;
    wr(A_CTRL, 32'h0, rs);
    gp_seven_out <= 1'b0;
    gp_six_out <= 1'b1;
    gp_six_oe <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({28'h0, shared_pin_seven_oe, shared_pin_seven_o, shared_pin_six_oe, shared_pin_six_o},
        32'h3, "pins to general use");
    gp_seven_out <= 1'b1;
    gp_seven_oe <= 1'b1;
    gp_six_oe <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({30'h0, shared_pin_seven_oe, shared_pin_six_oe}, 32'h2, "pins follow");
    bit_cyc <= 16'h000a;
    psend(8'h66);
    repeat (120) @(posedge clk_sys);
    rd(A_STAT, v, rs);
    chk(v, 32'h0, "no rx when off");
    wr(A_CTRL, 32'h1, rs);
    gp_seven_oe <= 1'b0;
    rd(A_STAT, v, rs);
    chk({31'h0, shared_pin_seven_oe}, 32'h1, "pin back to serial");
  endtask : t_disable

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_map();
    t_tx();
    t_rx();
    t_fifo();
    t_baud();
    t_disable();
    complete_run();
  end

  // Whole run is near 8000 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
endmodule : uart_buffer_status_data_tb_top
